// ### rtl/fcdma_pkg.sv
// constants and types shared by the four channel transfer engine
// assumes a 16-bit byte addressed data space and an 8-bit data path
package fcdma_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH = 4;
  localparam int DW = 8;
  localparam int FDEPTH = 8;

  // ****************************************
  // data space map
  // ****************************************
  localparam logic [15:0] EEP_BASE = 16'h1000; // read-only region start
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // ****************************************
  // block size and burst lengths
  // ****************************************
  localparam logic [16:0] BLK_FULL = 17'h10000; // count 0 means 64KB
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] BURST_TWO = 2'h2;

  // ****************************************
  // read pacing: eeprom yields a byte every second cycle
  // ****************************************
  localparam int EEP_RD_CYCLES = 2;
  localparam logic [1:0] EEP_GAP = 2'(EEP_RD_CYCLES - 1);
  localparam logic [1:0] SRAM_GAP = 2'h0;

  // ****************************************
  // trigger sources
  // ****************************************
  localparam logic [1:0] TRIG_SW = 2'h0;
  localparam logic [1:0] TRIG_PER = 2'h1;
  localparam logic [1:0] TRIG_EV = 2'h2;

  // ****************************************
  // address reload points
  // ****************************************
  localparam logic [1:0] RLD_NONE = 2'h0;
  localparam logic [1:0] RLD_BURST = 2'h1;
  localparam logic [1:0] RLD_BLOCK = 2'h2;
  localparam logic [1:0] RLD_TRANS = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_BURST} fcdma_st_t;

endpackage

// ### rtl/fcdma_top.sv
// four channel transfer engine with its byte fifo
// assumes read and write buses are separate, single clock, plain config ports
`timescale 1ns/1ns

// ****************************************
// byte fifo between read and write side
// ****************************************
module fcdma_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // fill level
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fcdma_fifo_st_t;

  fcdma_fifo_st_t s_r;
  fcdma_fifo_st_t s_nxt;
  logic push;
  logic pop;

  // handshakes straight from the count
  assign in_ready = s_r.cnt != (AW+1)'(D);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign level = s_r.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap by width, so depth is a power of two
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ****************************************
// channel engine
// ****************************************
// Behaviour
// - four channels, each with own source, destination, trigger and size
// - each burst moves one or two bytes, chosen per channel
// - a block is built of bursts, 1 byte to 64KB
// - repeat runs the block a second time, up to 128KB
// - source and destination each fixed or incremented per byte
// - optional address restore after burst, block or transaction
// - start by software, peripheral trigger or event, per channel select
// - per channel interrupt on completion or error, when enabled
// - linked channel takes over when the previous one finishes
// - a channel pair may combine into one standard channel with search
// - peripheral or standard type chosen per channel pair
// - match compare on peripheral channels, search stop on standard
// - moved bytes optionally fed to the checksum generator
// - eeprom region readable as source, never written
// - eeprom region starts at one fixed address
// - sram burst reads deliver a byte every cycle
// - eeprom burst reads deliver a byte every second cycle
// - single access latencies differ by memory; reads await data valid
// - read and write buses are separate and run in the same cycle
// - memory and peripheral in every direction
module fcdma_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // channel setup
  input wire logic [3:0] cfg_en,
  input wire logic [3:0][1:0] cfg_trig,
  input wire logic [3:0][1:0] cfg_prio,
  input wire logic [3:0][15:0] cfg_src,
  input wire logic [3:0][15:0] cfg_dst,
  input wire logic [3:0][15:0] cfg_cnt,
  input wire logic [3:0] cfg_b2,
  input wire logic [3:0] cfg_rep,
  input wire logic [3:0] cfg_sinc,
  input wire logic [3:0] cfg_dinc,
  input wire logic [3:0][1:0] cfg_srld,
  input wire logic [3:0][1:0] cfg_drld,
  input wire logic [3:0] cfg_link,
  input wire logic [3:0] cfg_ie,
  input wire logic [3:0] cfg_men,
  input wire logic [3:0][7:0] cfg_mval,
  input wire logic [3:0] cfg_crc,
  input wire logic [1:0] cfg_std,
  // starts and address loads
  input wire logic [3:0] addr_load,
  input wire logic [3:0] sw_trig,
  input wire logic [3:0] per_trig,
  input wire logic [3:0] ev_in,
  // read bus
  output logic rd_req,
  output logic [15:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // write bus
  output logic wr_req,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ack,
  // status
  output logic [3:0] ch_busy,
  output logic [3:0] irq_done,
  output logic [3:0] irq_err,
  output logic [3:0] ch_match,
  input wire logic [3:0] irq_clr,
  output logic crc_valid,
  output logic [7:0] crc_data
);

  typedef struct packed {
    logic [3:0] ev_s1;
    logic [3:0] ev_s2;
    logic [3:0] ev_s3;
    logic [3:0] pend;
    logic [3:0][15:0] src;
    logic [3:0][15:0] dst;
    logic [1:0] act;
    fcdma_pkg::fcdma_st_t st;
    logic [16:0] rem;
    logic pass2;
    logic stop;
    logic err;
    logic [1:0] rd_left;
    logic [1:0] wr_left;
    logic [1:0] outst;
    logic [1:0] gap;
    logic [3:0] irq_d;
    logic [3:0] irq_e;
    logic [3:0] hit;
    logic crc_v;
    logic [7:0] crc_d;
  } fcdma_state_t;

  fcdma_state_t s_r;
  fcdma_state_t s_nxt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic in_eep(input logic [15:0] addr);
    return addr >= fcdma_pkg::EEP_BASE;
  endfunction

  function automatic logic [16:0] blk(input logic [15:0] cnt);
    return (cnt == 16'h0000) ? fcdma_pkg::BLK_FULL : {1'b0, cnt};
  endfunction

  function automatic logic [1:0] blen(input logic b2, input logic [16:0] rem);
    return (b2 && rem >= 17'h00002) ? fcdma_pkg::BURST_TWO : fcdma_pkg::BURST_ONE;
  endfunction

  // highest priority wins, ties to the lower channel
  function automatic logic [2:0] pick_of(input logic [3:0] req, input logic [3:0][1:0] prio);
    logic any;
    logic [1:0] idx;
    any = 1'b0;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i] && (!any || prio[i] >= prio[idx])) begin
        any = 1'b1;
        idx = 2'(i);
      end
    end
    return {any, idx};
  endfunction

  logic [3:0] ev_rise;
  logic [3:0] trig;
  logic [3:0] ok;
  logic [2:0] pick;
  logic [1:0] a;
  logic is_std;
  logic room;
  logic rd_go;
  logic dst_bad;
  logic burst_end;
  logic blk_end;
  logic again;
  logic fin;
  logic f_ivalid;
  logic f_iready;
  logic f_ovalid;
  logic f_pop;
  logic [7:0] f_odata;
  logic [3:0] f_lvl;

  // event starts are looked at only after the second sync stage
  assign ev_rise = s_r.ev_s2 & ~s_r.ev_s3;

  // trigger mux per channel
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      trig[i] = (cfg_trig[i] == fcdma_pkg::TRIG_SW) ? sw_trig[i] :
                (cfg_trig[i] == fcdma_pkg::TRIG_PER) ? per_trig[i] :
                (cfg_trig[i] == fcdma_pkg::TRIG_EV) ? ev_rise[i] : 1'b0;
    end
  end

  // odd channel of a combined pair is absorbed by its even partner
  assign ok = cfg_en & ~{cfg_std[1], 1'b0, cfg_std[0], 1'b0};
  assign pick = pick_of(s_r.pend & ok, cfg_prio);
  assign a = s_r.act;
  assign is_std = !a[0] && cfg_std[a[1]];

  // read issue: fifo room counts reads still in flight, so it never overruns
  assign room = ({1'b0, f_lvl} + 5'(s_r.outst)) < 5'(fcdma_pkg::FDEPTH);
  assign rd_go = s_r.st == fcdma_pkg::ST_BURST && s_r.rd_left != 2'h0 && s_r.gap == 2'h0 && room;
  assign rd_req = rd_go;
  assign rd_addr = s_r.src[a];

  // write side drains in parallel with reads; eeprom targets are dropped
  assign dst_bad = in_eep(s_r.dst[a]);
  assign wr_req = s_r.st == fcdma_pkg::ST_BURST && f_ovalid && !dst_bad;
  assign wr_addr = s_r.dst[a];
  assign wr_data = f_odata;
  assign f_pop = f_ovalid && (dst_bad || wr_ack);
  assign f_ivalid = rd_valid;

  // burst, block and transaction boundaries
  assign burst_end = s_r.st == fcdma_pkg::ST_BURST && s_r.rd_left == 2'h0 && s_r.wr_left == 2'h0;
  assign blk_end = burst_end && (s_r.rem == 17'h00000 || s_r.stop);
  assign again = cfg_rep[a] && !s_r.pass2 && !s_r.stop;
  assign fin = blk_end && !again;

  assign ch_busy = (s_r.st == fcdma_pkg::ST_BURST) ? (4'h1 << a) : 4'h0;
  assign irq_done = s_r.irq_d;
  assign irq_err = s_r.irq_e;
  assign ch_match = s_r.hit;
  assign crc_valid = s_r.crc_v;
  assign crc_data = s_r.crc_d;

  fcdma_fifo #(
    .W(fcdma_pkg::DW),
    .D(fcdma_pkg::FDEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(f_ivalid),
    .in_ready(f_iready),
    .in_data(rd_data),
    .out_valid(f_ovalid),
    .out_ready(f_pop),
    .out_data(f_odata),
    .level(f_lvl)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ev_s1 = ev_in;
    s_nxt.ev_s2 = s_r.ev_s1;
    s_nxt.ev_s3 = s_r.ev_s2;
    s_nxt.crc_v = 1'b0;
    s_nxt.irq_d = s_r.irq_d & ~irq_clr;
    s_nxt.irq_e = s_r.irq_e & ~irq_clr;
    s_nxt.hit = s_r.hit & ~irq_clr;
    case (s_r.st)
      fcdma_pkg::ST_IDLE: begin
        // one channel owns both buses per transaction
        if (pick[2]) begin
          s_nxt.act = pick[1:0];
          s_nxt.pend[pick[1:0]] = 1'b0;
          s_nxt.rem = blk(cfg_cnt[pick[1:0]]);
          s_nxt.rd_left = blen(cfg_b2[pick[1:0]], blk(cfg_cnt[pick[1:0]]));
          s_nxt.wr_left = blen(cfg_b2[pick[1:0]], blk(cfg_cnt[pick[1:0]]));
          s_nxt.pass2 = 1'b0;
          s_nxt.stop = 1'b0;
          s_nxt.err = 1'b0;
          s_nxt.gap = fcdma_pkg::SRAM_GAP;
          s_nxt.st = fcdma_pkg::ST_BURST;
        end
      end
      fcdma_pkg::ST_BURST: begin
        // read issue, paced by the region being read
        if (rd_go) begin
          s_nxt.rd_left = s_r.rd_left - 2'h1;
          s_nxt.gap = in_eep(s_r.src[a]) ? fcdma_pkg::EEP_GAP : fcdma_pkg::SRAM_GAP;
          if (cfg_sinc[a]) begin
            s_nxt.src[a] = s_r.src[a] + 16'h0001;
          end
        end else if (s_r.gap != 2'h0) begin
          s_nxt.gap = s_r.gap - 2'h1;
        end
        s_nxt.outst = s_r.outst + 2'(rd_go) - 2'(rd_valid);
        // data compare as bytes return
        if (rd_valid && cfg_men[a] && rd_data == cfg_mval[a]) begin
          s_nxt.hit[a] = 1'b1;
          if (is_std) begin
            s_nxt.stop = 1'b1;
          end
        end
        // write completion or drop
        if (f_pop) begin
          s_nxt.wr_left = s_r.wr_left - 2'h1;
          s_nxt.rem = s_r.rem - 17'h00001;
          if (cfg_dinc[a]) begin
            s_nxt.dst[a] = s_r.dst[a] + 16'h0001;
          end
          if (dst_bad) begin
            s_nxt.err = 1'b1;
            s_nxt.stop = 1'b1;
          end else if (cfg_crc[a]) begin
            s_nxt.crc_v = 1'b1;
            s_nxt.crc_d = f_odata;
          end
        end
        // boundaries: restore addresses where asked
        if (burst_end) begin
          if (cfg_srld[a] == fcdma_pkg::RLD_BURST || (blk_end && cfg_srld[a] == fcdma_pkg::RLD_BLOCK) ||
              (fin && cfg_srld[a] == fcdma_pkg::RLD_TRANS)) begin
            s_nxt.src[a] = cfg_src[a];
          end
          if (cfg_drld[a] == fcdma_pkg::RLD_BURST || (blk_end && cfg_drld[a] == fcdma_pkg::RLD_BLOCK) ||
              (fin && cfg_drld[a] == fcdma_pkg::RLD_TRANS)) begin
            s_nxt.dst[a] = cfg_dst[a];
          end
          if (fin) begin
            s_nxt.irq_d[a] = s_nxt.irq_d[a] | cfg_ie[a];
            s_nxt.irq_e[a] = s_nxt.irq_e[a] | (cfg_ie[a] & s_r.err);
            if (cfg_link[a]) begin
              s_nxt.pend[a + 2'h1] = 1'b1;
            end
            s_nxt.st = fcdma_pkg::ST_IDLE;
          end else if (blk_end) begin
            s_nxt.pass2 = 1'b1;
            s_nxt.rem = blk(cfg_cnt[a]);
            s_nxt.rd_left = blen(cfg_b2[a], blk(cfg_cnt[a]));
            s_nxt.wr_left = blen(cfg_b2[a], blk(cfg_cnt[a]));
          end else begin
            s_nxt.rd_left = blen(cfg_b2[a], s_r.rem);
            s_nxt.wr_left = blen(cfg_b2[a], s_r.rem);
          end
        end
      end
      default: begin
        s_nxt.st = fcdma_pkg::ST_IDLE;
      end
    endcase
    // address loads are refused for the running channel
    for (int i = 0; i < 4; i++) begin
      if (addr_load[i] && !(s_r.st == fcdma_pkg::ST_BURST && s_r.act == 2'(i))) begin
        s_nxt.src[i] = cfg_src[i];
        s_nxt.dst[i] = cfg_dst[i];
      end
    end
    // starts last, so a trigger in the grant cycle is kept
    for (int i = 0; i < 4; i++) begin
      if (trig[i] && ok[i]) begin
        s_nxt.pend[i] = 1'b1;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= fcdma_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_eep_read_pace: assert property (rd_go && in_eep(rd_addr) |=> !rd_go)
    else $error("eeprom reads issued back to back");
  a_single_grant: assert property ($onehot0(ch_busy) && (ch_busy == 4'h0 || !s_r.pend[a]))
    else $error("more than one channel active");
  a_burst_one_len: assert property (s_r.st == fcdma_pkg::ST_IDLE && pick[2] && !cfg_b2[pick[1:0]]
    |=> s_r.rd_left == 2'h1 && s_r.wr_left == 2'h1)
    else $error("single byte burst misloaded");
  a_done_irq_set: assert property (fin && cfg_ie[a] |=> irq_done[$past(a)] ##1 1'b1)
    else $error("completion interrupt missing");
  a_link_takeover: assert property (fin && cfg_link[a] |=> s_r.pend[$past(a) + 2'h1])
    else $error("linked channel not started");
  a_no_eep_write: assert property (wr_req |-> wr_addr < fcdma_pkg::EEP_BASE)
    else $error("write into eeprom region");
  a_fifo_room: assert property (f_ivalid |-> f_iready)
    else $error("read data arrived with fifo full");
  a_block_range: assert property (s_r.st == fcdma_pkg::ST_BURST |-> s_r.rem <= fcdma_pkg::BLK_FULL)
    else $error("block count out of range");
  a_repeat_pass: assert property (blk_end && again |=> s_r.pass2 && s_r.rem == blk(cfg_cnt[a]))
    else $error("repeat did not start a second block");
  a_src_step: assert property (rd_go && cfg_sinc[a] |=> rd_addr == $past(rd_addr) + 16'h0001)
    else $error("source did not increment");

  c_repeat_done: cover property (fin && s_r.pass2);
  c_link_run: cover property (fin && cfg_link[a] ##[1:20] ch_busy != 4'h0);
  c_eep_burst: cover property (rd_go && in_eep(rd_addr) ##2 rd_go);
  c_search_stop: cover property (s_r.stop && fin && is_std);
endmodule

// ### testbench/fcdma_mem_model.sv
// far side model: data memory read bus and write bus
// assumes requests change only on the rising edge of clk
`timescale 1ns/1ns
module fcdma_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pacing chosen by the bench
  input wire logic slow,
  // read bus
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // write bus
  input wire logic wr_req,
  output logic wr_ack
);
  logic [15:0] pend_q[$];
  logic [15:0] a;
  // ****************************************
  // read side
  // ****************************************
  // answers in order, one byte a cycle at best, later when slow
  always @(posedge clk) begin
    rd_valid <= 1'b0;
    rd_data <= ~rd_data; // never leave a stale byte on the lines
    if (!rstn) begin
      pend_q.delete();
      rd_data <= 8'hA5;
    end else begin
      if (pend_q.size() > 0 && (!slow || $urandom_range(1, 0) == 1)) begin
        a = pend_q.pop_front();
        rd_valid <= 1'b1;
        rd_data <= a[7:0] ^ a[15:8] ^ 8'h3C;
      end
      if (rd_req) begin
        pend_q.push_back(rd_addr);
      end
    end
  end
  // ****************************************
  // write side
  // ****************************************
  // separate bus, accepts in the same cycles as reads; stalls when slow
  always @(posedge clk) begin
    wr_ack <= rstn && (!slow || $urandom_range(1, 0) == 1);
  end
endmodule

// ### testbench/fcdma_top_test.sv
// self-checking bench for the four channel transfer engine
// assumes fcdma_mem_model answers read and write buses
`timescale 1ns/1ns
module fcdma_top_test;
  logic clk = 1'b0;
  logic rstn, slow;
  logic [3:0] cfg_en, cfg_b2, cfg_rep, cfg_sinc, cfg_dinc, cfg_link, cfg_ie, cfg_men, cfg_crc;
  logic [3:0] addr_load, sw_trig, per_trig, ev_in, irq_clr;
  logic [3:0][1:0] cfg_trig, cfg_prio, cfg_srld, cfg_drld;
  logic [3:0][15:0] cfg_src, cfg_dst, cfg_cnt;
  logic [3:0][7:0] cfg_mval;
  logic [1:0] cfg_std;
  logic rd_req, rd_valid, wr_req, wr_ack, crc_valid;
  logic [15:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data, crc_data;
  logic [3:0] ch_busy, irq_done, irq_err, ch_match;
  logic [23:0] exp_q[$];
  logic [15:0] ms[4], md[4];
  logic [31:0] r;
  logic [23:0] e;
  logic [7:0] last_wd = 8'h00;
  logic prev_rd = 1'b0;
  int miscompares = 0, tests_run = 0, crc_cnt = 0, cyc = 0, last_ee = -10, btb = 0;

  fcdma_top u_fcdma_top (.clk, .rstn, .cfg_en, .cfg_trig, .cfg_prio, .cfg_src, .cfg_dst, .cfg_cnt,
    .cfg_b2, .cfg_rep, .cfg_sinc, .cfg_dinc, .cfg_srld, .cfg_drld, .cfg_link, .cfg_ie, .cfg_men,
    .cfg_mval, .cfg_crc, .cfg_std, .addr_load, .sw_trig, .per_trig, .ev_in, .rd_req, .rd_addr,
    .rd_valid, .rd_data, .wr_req, .wr_addr, .wr_data, .wr_ack, .ch_busy, .irq_done, .irq_err,
    .ch_match, .irq_clr, .crc_valid, .crc_data);
  fcdma_mem_model u_fcdma_mem_model (.clk, .rstn, .slow, .rd_req, .rd_addr, .rd_valid, .rd_data,
    .wr_req, .wr_ack);

  // 125 MHz clock
  always #4 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] f(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // restore the model addresses at a given reload point
  task automatic reld(int ch, logic [1:0] pt);
    if (cfg_srld[ch] == pt) ms[ch] = cfg_src[ch];
    if (cfg_drld[ch] == pt) md[ch] = cfg_dst[ch];
  endtask

  // configure a channel, load its addresses and note the writes it must make
  task automatic setup(int ch, logic [15:0] s, d, int n, bit b2, rep, si, di, logic [1:0] sr, dr, bit w);
    cfg_en[ch] = 1'b1;
    cfg_trig[ch] = 2'h3;
    cfg_src[ch] = s;
    cfg_dst[ch] = d;
    cfg_cnt[ch] = 16'(n);
    {cfg_b2[ch], cfg_rep[ch], cfg_sinc[ch], cfg_dinc[ch]} = {b2, rep, si, di};
    cfg_srld[ch] = sr;
    cfg_drld[ch] = dr;
    addr_load[ch] = 1'b1;
    tick();
    addr_load[ch] = 1'b0;
    ms[ch] = s;
    md[ch] = d;
    for (int b = 0; b < (rep ? 2 : 1); b++) begin
      for (int i = 0; i < n; i++) begin
        if (w) exp_q.push_back({md[ch], f(ms[ch])});
        ms[ch] += 16'(si);
        md[ch] += 16'(di);
        if (!b2 || i % 2 == 1 || i == n - 1) reld(ch, 2'h1);
      end
      reld(ch, 2'h2);
    end
    reld(ch, 2'h3);
  endtask

  // start the channels of mk by the chosen source
  task automatic fire(logic [3:0] mk, logic [1:0] k);
    for (int c = 0; c < 4; c++) if (mk[c]) cfg_trig[c] = k;
    tick();
    if (k == 2'h0) sw_trig = mk;
    if (k == 2'h1) per_trig = mk;
    if (k == 2'h2) ev_in = mk;
    tick();
    sw_trig = 4'h0;
    per_trig = 4'h0;
    tick(2);
    ev_in = 4'h0;
  endtask

  // wait for all noted writes and idle channels, then check the flags
  task automatic finish(string nm, logic [3:0] dn, er, mt);
    int k;
    k = 0;
    tick(4);
    while ((exp_q.size() > 0 || ch_busy !== 4'h0) && k < 3000) begin
      tick();
      k++;
    end
    tick(3);
    chk("left", exp_q.size(), 0);
    chk("busy", ch_busy, 0);
    chk("done", irq_done, dn);
    chk("err", irq_err, er);
    chk("match", ch_match, mt);
    irq_clr = 4'hF;
    tick();
    irq_clr = 4'h0;
    {cfg_en, cfg_link, cfg_men} = '0;
    $display("test %s ended", nm);
  endtask

  // ****************************************
  // result watcher
  // ****************************************
  // every accepted byte is matched against the oldest note
  always @(negedge clk) begin
    cyc++;
    // checksum byte follows its write by one cycle, so look before taking the next note
    if (crc_valid) begin
      crc_cnt++;
      chk("crc_data", crc_data, last_wd);
    end
    if (rstn && wr_req && wr_ack) begin
      chk("wr_dst", wr_addr < 16'h1000, 1);
      if (exp_q.size() == 0) begin
        chk("wr_extra", 1, 0);
      end else begin
        e = exp_q.pop_front();
        chk("wr", {wr_addr, wr_data}, e);
        last_wd = e[7:0];
      end
    end
    if (rstn && rd_req && rd_addr >= 16'h1000) begin
      chk("ee_gap", cyc - last_ee >= 2, 1);
      last_ee = cyc;
    end
    if (rd_req && rd_addr < 16'h1000 && prev_rd) btb++;
    prev_rd = rd_req && rd_addr < 16'h1000;
  end

  // hang guard, well past the expected run length
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rstn, slow, cfg_en, cfg_b2, cfg_rep, cfg_sinc, cfg_dinc, cfg_link, cfg_men, cfg_crc} = '0;
    {addr_load, sw_trig, per_trig, ev_in, irq_clr, cfg_trig, cfg_prio, cfg_srld, cfg_drld} = '0;
    {cfg_src, cfg_dst, cfg_cnt, cfg_mval, cfg_std} = '0;
    cfg_ie = 4'hF;
    r = $urandom(32'hA34E);
    tick(3);
    rstn = 1'b1;
    tick();
    // combined standard channel, two-byte bursts, odd block, checksum feed
    cfg_std = 2'h1;
    cfg_crc = 4'h1;
    setup(0, 16'h0200, 16'h0400, 5, 1, 0, 1, 1, 2'h0, 2'h0, 1);
    fire(4'h1, 2'h0);
    finish("basic", 4'h1, 4'h0, 4'h0);
    chk("crc", crc_cnt, 5);
    chk("btb", btb > 0, 1);
    {cfg_std, cfg_crc} = '0;
    // random modes on every channel, each start source, stalling far side
    slow = 1'b1;
    for (int c = 0; c < 4; c++) begin
      r = $urandom;
      cfg_ie = (c == 3) ? 4'h7 : 4'hF;
      setup(c, 16'h0100 + 16'(r[7:0]), 16'h0800 + 16'(r[15:8]), 1 + int'(r[18:16]), r[19], r[20],
        r[21], r[22], r[24:23], r[26:25], 1);
      fire(4'(1 << c), 2'(c % 3));
      finish("mode", cfg_ie & 4'(1 << c), 4'h0, 4'h0);
    end
    cfg_ie = 4'hF;
    // read-only region as source, paced reads
    setup(1, 16'h1000, 16'h0300, 6, 1, 0, 1, 1, 2'h0, 2'h0, 1);
    fire(4'h2, 2'h0);
    finish("eeprom", 4'h2, 4'h0, 4'h0);
    // write into the read-only region is refused
    setup(2, 16'h0200, 16'h1010, 4, 0, 0, 1, 1, 2'h0, 2'h0, 0);
    fire(4'h4, 2'h0);
    finish("error", 4'h4, 4'h4, 4'h0);
    // priority: channel 2 above channel 1, both started together
    cfg_prio[2] = 2'h3;
    cfg_prio[1] = 2'h0;
    setup(2, 16'h0210, 16'h0600, 3, 0, 0, 1, 1, 2'h0, 2'h0, 1);
    setup(1, 16'h0220, 16'h0500, 3, 0, 0, 1, 1, 2'h0, 2'h0, 1);
    fire(4'h6, 2'h0);
    finish("prio", 4'h6, 4'h0, 4'h0);
    // linked channels: 3 follows 2 without its own start
    setup(2, 16'h0230, 16'h0700, 4, 1, 0, 1, 0, 2'h0, 2'h0, 1);
    setup(3, 16'h0240, 16'h0710, 3, 0, 0, 0, 1, 2'h0, 2'h0, 1);
    cfg_link[2] = 1'b1;
    fire(4'h4, 2'h0);
    finish("link", 4'hC, 4'h0, 4'h0);
    // match compare on a peripheral channel
    cfg_men[0] = 1'b1;
    cfg_mval[0] = f(16'h0242);
    setup(0, 16'h0240, 16'h0900, 4, 1, 0, 1, 1, 2'h0, 2'h0, 1);
    fire(4'h1, 2'h0);
    finish("match", 4'h1, 4'h0, 4'h1);
    // search on the upper combined pair: ends after the burst holding the hit
    cfg_std = 2'h2;
    cfg_men[2] = 1'b1;
    cfg_mval[2] = f(16'h0252);
    setup(2, 16'h0250, 16'h0A00, 6, 1, 0, 1, 1, 2'h0, 2'h0, 0);
    for (int i = 0; i < 4; i++) exp_q.push_back({16'h0A00 + 16'(i), f(16'h0250 + 16'(i))});
    fire(4'h4, 2'h0);
    finish("search", 4'h4, 4'h0, 4'h4);
    cfg_std = 2'h0;
    give_verdict();
  end
endmodule
